//--- brf_pkg.sv
// Package of constants and types for the banked register file and decoder
package brf_pkg;

  // --------------------------------------------------------------------------
  // Register offsets in the standard file
  // --------------------------------------------------------------------------
  localparam logic [7:0] BRF_RSV0_ADDR   = 8'h00;   // Reserved location
  localparam logic [7:0] BRF_RSV1_ADDR   = 8'h01;   // Reserved location
  localparam logic [7:0] BRF_PORT2_ADDR  = 8'h02;   // First port register
  localparam logic [7:0] BRF_PORT3_ADDR  = 8'h03;   // Second port register
  localparam logic [7:0] BRF_WREG_LO     = 8'hE0;   // First location refused in direct mode
  localparam logic [7:0] BRF_WREG_HI     = 8'hEF;   // Last location refused in direct mode
  localparam logic [7:0] BRF_RSV2_ADDR   = 8'hF0;   // Reserved location
  localparam logic [7:0] BRF_PTR_ADDR    = 8'hFD;   // Register pointer

  // --------------------------------------------------------------------------
  // Reset values and sizes
  // --------------------------------------------------------------------------
  localparam logic [7:0] BRF_PTR_RST     = 8'h00;   // Pointer after reset
  localparam logic [7:0] BRF_PORT_RST    = 8'h00;   // Port latches after reset
  localparam logic [7:0] BRF_DATA_RST    = 8'h00;   // Read data after reset
  localparam int         BRF_MEM_DEPTH   = 512;     // Words in the storage array
  localparam int         BRF_MEM_AW      = 9;       // Storage index width

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  // Addressing mode of one core access
  typedef enum logic [1:0] {
    BRF_DIRECT,
    BRF_INDIRECT,
    BRF_WORKING
  } brf_mode_t;

  // Where a decoded access lands
  typedef enum logic [2:0] {
    BRF_TGT_NONE,
    BRF_TGT_MEM,
    BRF_TGT_PTR,
    BRF_TGT_PORT2,
    BRF_TGT_PORT3
  } brf_tgt_t;

  // Map a bank number to its storage slot; bit 3 set means no storage
  function automatic logic [3:0] brf_bank_slot(input logic [3:0] bank);
    logic [3:0] slot;
    slot = 4'h8;
    case (bank)
      4'h4:    slot = 4'h0;
      4'h5:    slot = 4'h1;
      4'h6:    slot = 4'h2;
      4'h7:    slot = 4'h3;
      4'hA:    slot = 4'h4;
      4'hB:    slot = 4'h5;
      4'hC:    slot = 4'h6;
      4'hF:    slot = 4'h7;
      default: slot = 4'h8;
    endcase
    return slot;
  endfunction : brf_bank_slot

endpackage : brf_pkg

//--- brf_mem_if.sv
// Interface between the decoder and its storage array
`timescale 1ns/1ps
interface brf_mem_if;
  logic [8:0] addr;   // Storage index
  logic       we;     // Write strobe
  logic [7:0] wdata;  // Write data
  logic [7:0] rdata;  // Registered read data

  // Decoder side
  modport ctl (output addr, output we, output wdata, input rdata);
  // Storage side
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : brf_mem_if

//--- brf_mem.sv
// Storage array for the standard file and the expanded banks
`timescale 1ns/1ps
module brf_mem (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic sys_rst_in,
  // Decoder connection
  brf_mem_if.mem    bus
);
  import brf_pkg::*;

  // --------------------------------------------------------------------------
  // Array and read register
  // --------------------------------------------------------------------------
  logic [7:0] mem_q [BRF_MEM_DEPTH];   // Contents, not reset
  logic [7:0] rdata_q;                 // Read data register

  // Write port
  always_ff @(posedge clk_sys_in) begin
    if (bus.we) begin
      mem_q[bus.addr] <= bus.wdata;
    end
  end

  // Read port, one cycle behind the index
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_q <= BRF_DATA_RST;
    end else begin
      rdata_q <= mem_q[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;

endmodule : brf_mem

//--- brf_top.sv
// Register file decoder with pointer, ports and banked storage
`timescale 1ns/1ps
module brf_top (
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              sys_rst_in,
  // Core access port
  input  wire logic              req_in,
  input  wire logic              we_in,
  input  wire brf_pkg::brf_mode_t mode_in,
  input  wire logic [7:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  output logic [7:0]             rdata_out,
  output logic                   rvalid_out,
  // Port pins
  input  wire logic [7:0]        port2_pin_in,
  input  wire logic [7:0]        port3_pin_in,
  output logic [7:0]             port2_out,
  output logic [7:0]             port3_out,
  // Pointer state
  output logic [7:0]             pointer_out
);
  import brf_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0] ptr_q;                  // Register pointer
  logic [7:0] p2_q, p3_q;             // Port output latches
  logic [7:0] p2_s1_q, p2_s2_q;       // Port 2 pin synchroniser
  logic [7:0] p3_s1_q, p3_s2_q;       // Port 3 pin synchroniser
  logic [7:0] eff_addr;               // Effective 8-bit address
  logic       in_bank;                // Access falls in the banked window
  logic [3:0] slot;                   // Storage slot of selected bank
  brf_tgt_t   tgt;                    // Decoded target
  logic [8:0] mem_idx;                // Storage index
  brf_tgt_t   tgt_q;                  // Target of pending read
  logic       rd_q;                   // Read pipeline valid
  logic [7:0] side_q;                 // Non-memory read data

  brf_mem_if  mif ();                 // Storage connection

  // --------------------------------------------------------------------------
  // Address formation
  // --------------------------------------------------------------------------
  // Direct and indirect accesses carry the full address; only working
  // mode borrows the group nibble, so the same number reaches any group
  // Working mode joins group nibble with register number
  always_comb begin
    if (mode_in == BRF_WORKING) begin
      eff_addr = {ptr_q[7:4], addr_in[3:0]};
    end else begin
      eff_addr = addr_in;
    end
  end

  // Banked window and slot lookup
  always_comb begin
    slot    = brf_bank_slot(ptr_q[3:0]);
    in_bank = (ptr_q[3:0] != 4'h0) && (eff_addr[7:4] == 4'h0);
  end

  // --------------------------------------------------------------------------
  // Target decode
  // --------------------------------------------------------------------------
  always_comb begin
    tgt     = BRF_TGT_MEM;
    mem_idx = {1'b0, eff_addr};
    if (in_bank) begin
      // Bank registers replace the lowest sixteen locations
      if (slot[3]) begin
        tgt = BRF_TGT_NONE;
      end else begin
        mem_idx = {2'b11, slot[2:0], eff_addr[3:0]};
      end
    end else if ((eff_addr == BRF_RSV0_ADDR) || (eff_addr == BRF_RSV1_ADDR) ||
                 (eff_addr == BRF_RSV2_ADDR)) begin
      tgt = BRF_TGT_NONE;
    end else if (eff_addr == BRF_PORT2_ADDR) begin
      tgt = BRF_TGT_PORT2;
    end else if (eff_addr == BRF_PORT3_ADDR) begin
      tgt = BRF_TGT_PORT3;
    end else if (eff_addr == BRF_PTR_ADDR) begin
      tgt = BRF_TGT_PTR;
    end else if ((mode_in == BRF_DIRECT) && (eff_addr >= BRF_WREG_LO) &&
                 (eff_addr <= BRF_WREG_HI)) begin
      tgt = BRF_TGT_NONE;
    end else if ((mode_in != BRF_DIRECT) && (mode_in != BRF_INDIRECT) &&
                 (mode_in != BRF_WORKING)) begin
      tgt = BRF_TGT_NONE;                                     // Unused mode code
    end
    // Remaining standard locations are plain storage bytes
  end

  // Standard file uses indices 000h-0FFh; the eight backed banks sit at
  // 180h-1FFh, sixteen bytes each, so no bank can alias a standard byte
  // Storage strobes
  assign mif.addr  = mem_idx;
  assign mif.we    = req_in && we_in && (tgt == BRF_TGT_MEM);
  assign mif.wdata = wdata_in;

  brf_mem u_mem (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .bus        (mif.mem)
  );

  // --------------------------------------------------------------------------
  // Pointer and port latches
  // --------------------------------------------------------------------------
  // Pointer register steers working-mode and banked decoding
  // A write here changes the decode of the very next request
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ptr_q <= BRF_PTR_RST;
    end else if (req_in && we_in && (tgt == BRF_TGT_PTR)) begin
      ptr_q <= wdata_in;
    end
  end

  // First port output latch
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      p2_q <= BRF_PORT_RST;
    end else if (req_in && we_in && (tgt == BRF_TGT_PORT2)) begin
      p2_q <= wdata_in;
    end
  end

  // Second port output latch
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      p3_q <= BRF_PORT_RST;
    end else if (req_in && we_in && (tgt == BRF_TGT_PORT3)) begin
      p3_q <= wdata_in;
    end
  end

  // First port pin synchroniser, two stages; only stage two is read
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      p2_s1_q <= BRF_PORT_RST;
      p2_s2_q <= BRF_PORT_RST;
    end else begin
      p2_s1_q <= port2_pin_in;
      p2_s2_q <= p2_s1_q;
    end
  end

  // Second port pin synchroniser, two stages; only stage two is read
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      p3_s1_q <= BRF_PORT_RST;
      p3_s2_q <= BRF_PORT_RST;
    end else begin
      p3_s1_q <= port3_pin_in;
      p3_s2_q <= p3_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Read pipeline
  // --------------------------------------------------------------------------
  // Stage one: capture target and side data
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rd_q   <= 1'b0;
      tgt_q  <= BRF_TGT_NONE;
      side_q <= BRF_DATA_RST;
    end else begin
      rd_q  <= req_in && !we_in;
      tgt_q <= tgt;
      // Ports read the synchronised pins, never the output latch
      case (tgt)
        BRF_TGT_PTR:   side_q <= ptr_q;
        BRF_TGT_PORT2: side_q <= p2_s2_q;
        BRF_TGT_PORT3: side_q <= p3_s2_q;
        default:       side_q <= BRF_DATA_RST;   // Unbacked reads give zero
      endcase
    end
  end

  // Stage two: select storage or side data, held until the next read
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_out <= BRF_DATA_RST;
    end else if (rd_q) begin
      // Storage answers from its own read register, others from side_q
      rdata_out <= (tgt_q == BRF_TGT_MEM) ? mif.rdata : side_q;
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  // Read valid pulse, in step with the read data register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_q;
    end
  end

  // Port outputs follow their latches one cycle later
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      port2_out <= BRF_PORT_RST;
      port3_out <= BRF_PORT_RST;
    end else begin
      port2_out <= p2_q;
      port3_out <= p3_q;
    end
  end

  // Pointer copy for the core, one cycle behind the pointer
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pointer_out <= BRF_PTR_RST;
    end else begin
      pointer_out <= ptr_q;
    end
  end

endmodule : brf_top

//--- brf_top_monitor.sv
// Concurrent checks on the register file decoder ports
`timescale 1ns/1ps
module brf_top_monitor (
  // Clock, reset and core access
  input wire logic               clk_sys_in,
  input wire logic               sys_rst_in,
  input wire logic               req_in,
  input wire logic               we_in,
  input wire brf_pkg::brf_mode_t mode_in,
  input wire logic [7:0]         addr_in,
  input wire logic [7:0]         wdata_in,
  // Observed outputs
  input wire logic [7:0]         rdata_out,
  input wire logic               rvalid_out,
  input wire logic [7:0]         port2_out,
  input wire logic [7:0]         pointer_out
);
  import brf_pkg::*;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  wire rd  = req_in && !we_in;         // Read taken this edge
  wire dir = mode_in == BRF_DIRECT;    // Plain direct address
  // --------------------------------------------------------------
  // Read handshake
  // --------------------------------------------------------------
  property p_rv; rd |-> ##2 rvalid_out; endproperty
  a_rv: assert property (p_rv) else $error("read got no valid pulse");
  property p_norv; rvalid_out |-> $past(rd, 2); endproperty
  a_norv: assert property (p_norv) else $error("valid pulse without read");
  property p_hold; !rvalid_out |-> $stable(rdata_out); endproperty
  a_hold: assert property (p_hold) else $error("read data moved idle");
  // --------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------
  property p_ptr; req_in && we_in && dir && addr_in == BRF_PTR_ADDR |-> ##2 pointer_out == $past(wdata_in, 2); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not written");
  property p_port; (req_in && we_in && dir && addr_in == BRF_PORT2_ADDR) ##1 (pointer_out[3:0] == 4'h0)
    |-> ##1 port2_out == $past(wdata_in, 2); endproperty
  a_port: assert property (p_port) else $error("port latch not written");
  property p_rsv; (rd && dir && addr_in inside {8'h00, 8'h01, 8'hF0}) ##1 (pointer_out[3:0] == 4'h0)
    |-> ##1 rdata_out == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read not zero");
  property p_e0; rd && dir && addr_in[7:4] == 4'hE |-> ##2 rdata_out == 8'h00; endproperty
  a_e0: assert property (p_e0) else $error("direct E0-EF not refused");
  property p_unbk; (rd && dir && addr_in[7:4] == 4'h0) ##1
    (pointer_out[3:0] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hD, 4'hE})
    |-> ##1 rdata_out == 8'h00; endproperty
  a_unbk: assert property (p_unbk) else $error("unbacked bank read not zero");
endmodule : brf_top_monitor
bind brf_top brf_top_monitor i_brf_top_monitor (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
  .req_in(req_in), .we_in(we_in), .mode_in(mode_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .rdata_out(rdata_out), .rvalid_out(rvalid_out), .port2_out(port2_out), .pointer_out(pointer_out));

//--- brf_core_model.sv
// Core-side access model driving the register file request port
`timescale 1ns/1ps
module brf_core_model (
  input  wire logic         clk_sys_in,
  input  wire logic         rvalid_out,
  input  wire logic [7:0]   rdata_out,
  output logic              req_in,
  output logic              we_in,
  output brf_pkg::brf_mode_t mode_in,
  output logic [7:0]        addr_in,
  output logic [7:0]        wdata_in
);
  import brf_pkg::*;
  initial begin
    req_in <= 1'b0;
    we_in <= 1'b0;
    mode_in <= BRF_DIRECT;
    addr_in <= 8'h00;
    wdata_in <= 8'h00;
  end
  // One access; released address and data lines show the inverse so stale values never pass
  task automatic acc(input logic w, input brf_mode_t m, input logic [7:0] a, d, output logic [7:0] r);
    r = 8'hxx;
    req_in <= 1'b1;
    we_in <= w;
    mode_in <= m;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_sys_in);
    req_in <= 1'b0;
    addr_in <= ~a;
    wdata_in <= ~d;
    for (int n = 0; n < 3; n++) begin
      @(posedge clk_sys_in);
      if (!w && rvalid_out === 1'b1) r = rdata_out;
    end
  endtask : acc
endmodule : brf_core_model

//--- brf_top_tb.sv
// Self-checking testbench for the banked register file decoder
`timescale 1ns/1ps
module brf_top_tb;
  import brf_pkg::*;
  logic clk_sys_in = 1'b0, sys_rst_in = 1'b1, req_in, we_in, rvalid_out;
  brf_mode_t mode_in;
  logic [7:0] addr_in, wdata_in, rdata_out, port2_out, port3_out, pointer_out;
  logic [7:0] port2_pin_in = 8'h96, port3_pin_in = 8'h69;  // Fixed pin levels
  int n_fail = 0, n_checks = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  brf_top i_brf_top (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .req_in(req_in), .we_in(we_in),
    .mode_in(mode_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .port2_pin_in(port2_pin_in), .port3_pin_in(port3_pin_in), .port2_out(port2_out), .port3_out(port3_out),
    .pointer_out(pointer_out));
  brf_core_model i_brf_core_model (.clk_sys_in(clk_sys_in), .rvalid_out(rvalid_out), .rdata_out(rdata_out),
    .req_in(req_in), .we_in(we_in), .mode_in(mode_in), .addr_in(addr_in), .wdata_in(wdata_in));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input brf_mode_t m, input logic [7:0] a, d);
    logic [7:0] r;
    i_brf_core_model.acc(1'b1, m, a, d, r);
  endtask : wr
  task automatic rd(input brf_mode_t m, input logic [7:0] a, output logic [7:0] r);
    i_brf_core_model.acc(1'b0, m, a, 8'h00, r);
  endtask : rd
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_std();
    logic [7:0] v;
    @(posedge clk_sys_in);
    chk("pointer_rst", pointer_out, BRF_PTR_RST);
    chk("port2_rst", port2_out, BRF_PORT_RST);
    wr(BRF_DIRECT, 8'h04, 8'hA5);
    wr(BRF_DIRECT, 8'hF1, 8'h3C);
    wr(BRF_DIRECT, 8'h02, 8'h5A);
    wr(BRF_DIRECT, 8'h03, 8'hC3);
    chk("port2_out", port2_out, 8'h5A);
    chk("port3_out", port3_out, 8'hC3);
    rd(BRF_DIRECT, 8'h04, v);
    chk("r04", v, 8'hA5);
    rd(BRF_DIRECT, 8'hF1, v);
    chk("rF1", v, 8'h3C);
    rd(BRF_DIRECT, 8'h02, v);
    chk("pins2", v, 8'h96);
    rd(BRF_DIRECT, 8'h03, v);
    chk("pins3", v, 8'h69);
    for (int i = 0; i < 3; i++) begin
      wr(BRF_DIRECT, (i == 2) ? 8'hF0 : 8'(i), 8'h77);
      rd(BRF_DIRECT, (i == 2) ? 8'hF0 : 8'(i), v);
      chk("reserved", v, 8'h00);
    end
  endtask : t_std
  task automatic t_modes();
    logic [7:0] v;
    wr(BRF_INDIRECT, 8'hE5, 8'h33);
    rd(BRF_DIRECT, 8'hE5, v);
    chk("dirE5", v, 8'h00);
    rd(BRF_INDIRECT, 8'hE5, v);
    chk("indE5", v, 8'h33);
    wr(BRF_DIRECT, 8'h10, 8'h11);
    wr(brf_mode_t'(2'h3), 8'h10, 8'h44);
    rd(brf_mode_t'(2'h3), 8'h10, v);
    chk("mode3_rd", v, 8'h00);
    rd(BRF_DIRECT, 8'h10, v);
    chk("mode3_wr", v, 8'h11);
    wr(BRF_DIRECT, BRF_PTR_ADDR, 8'h70);
    chk("pointer", pointer_out, 8'h70);
    wr(BRF_WORKING, 8'h03, 8'h9C);
    rd(BRF_DIRECT, 8'h73, v);
    chk("work73", v, 8'h9C);
    wr(BRF_DIRECT, BRF_PTR_ADDR, 8'h00);
  endtask : t_modes
  task automatic t_bank();
    logic [7:0] v;
    wr(BRF_DIRECT, 8'h05, 8'hEE);
    for (int b = 1; b < 16; b++) begin
      wr(BRF_DIRECT, BRF_PTR_ADDR, 8'(b));
      wr(BRF_DIRECT, 8'h05, {b[3:0], 4'h5});
      rd(BRF_DIRECT, 8'h05, v);
      chk("bank", v, (b inside {4, 5, 6, 7, 10, 11, 12, 15}) ? {b[3:0], 4'h5} : 8'h00);
    end
    wr(BRF_DIRECT, BRF_PTR_ADDR, 8'h00);
    rd(BRF_DIRECT, 8'h05, v);
    chk("std05", v, 8'hEE);
  endtask : t_bank
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  initial begin
    repeat (3) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    t_std();
    t_modes();
    t_bank();
    stop_test();
  end
endmodule : brf_top_tb
